// ---- rtl/ptc_pkg.sv ----
// Purpose: Shared constants and types for the two-wire control port.
// Assumes: 20 MHz system clock, host clock far slower than that.
// Notes: Register offsets are 16-bit register-map addresses.
package ptc_pkg;

  // Seven-bit slave addresses selected by the address strap.
  localparam logic [6:0] PTC_DEV_ADDR_STRAP_LOW = 7'h34;
  localparam logic [6:0] PTC_DEV_ADDR_STRAP_HIGH = 7'h36;

  // Register map.
  localparam logic [15:0] PTC_REG_SERIAL_PORT_CONTROL = 16'h4007;
  localparam int PTC_STEP_BIT = 2;
  localparam logic [15:0] PTC_CTRL_RESET = 16'h0004;
  localparam logic [15:0] PTC_CTRL_WMASK = 16'h0004;
  localparam logic [15:0] PTC_ADDR_STEP = 16'h0001;
  localparam logic [15:0] PTC_ADDR_RESET = 16'h0000;
  localparam logic [15:0] PTC_WORD_RESET = 16'h0000;

  // Serial framing.
  localparam logic [3:0] PTC_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] PTC_BIT_FIRST = 4'h0;
  localparam logic [3:0] PTC_BIT_STEP = 4'h1;
  localparam logic [7:0] PTC_BYTE_RELEASED = 8'hFF;
  localparam logic [7:0] PTC_BYTE_RESET = 8'h00;

  // Meaning of the byte being received within a frame.
  localparam logic [1:0] PTC_IDX_DEVICE = 2'h0;
  localparam logic [1:0] PTC_IDX_ADDR_HI = 2'h1;
  localparam logic [1:0] PTC_IDX_ADDR_LO = 2'h2;
  localparam logic [1:0] PTC_IDX_DATA = 2'h3;
  localparam logic [1:0] PTC_IDX_STEP = 2'h1;

  typedef enum logic [4:0] {
    PTC_IDLE = 5'h01,
    PTC_RECV = 5'h02,
    PTC_ACK = 5'h04,
    PTC_SEND = 5'h08,
    PTC_MACK = 5'h10
  } ptc_state_t;

  // Request to the device register map.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ptc_reg_req_t;

endpackage

// ---- rtl/ptc_two_wire_port.sv ----
// Purpose: Two-wire slave control port giving a host access to the 16-bit register map.
// Assumes: Serial pins are asynchronous and oversampled; the map answers a read one cycle later.
// Notes: The four-wire mode is outside this block; the port sits idle while it is selected.
//
// What this block does
// - Low select pin enables two-wire access.
// - Slave only; clock input, data bidirectional.
// - Logic one released, never driven high.
// - Address strap picks 0110100x or 0110110x.
// - Address byte LSB: one read, zero write.
// - After start, shift address byte MSB first.
// - Matching address acknowledged by low data.
// - Mismatch or refused read: idle until start.
// - Stop ends transfer; device returns idle.
// - Misplaced start or stop abandons transfer.
// - 16-bit register address follows slave address.
// - Single and stepped multiple reads, writes.
// - Multiple access needs step bit, 4007h bit2.
// - Address advances after each written word, before each further read word.
// - Every register readable over data pin.
// - Each access carries one 16-bit word.
module ptc_two_wire_port
  import ptc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic interface_select_pin,
  input wire logic address_select_pin,
  input wire logic write_only_mode,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output ptc_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  output logic address_step_enable
);

  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic sel_m, sel_s;
  logic asel_m, asel_s;
  ptc_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] hi_byte;
  logic [1:0] byte_idx;
  logic data_lo;
  logic rw;
  logic words_done;
  logic [15:0] tx_word;
  logic [15:0] ctrl;
  logic rd_d1;

  logic scl_rise, scl_fall, start_cond, stop_cond, two_wire;
  logic byte_done, accept, dev_match, fetch_first, fetch_next, fetch_req;
  logic ctrl_hit, word_write;
  logic [6:0] own_addr;
  logic [7:0] tx_byte, next_byte;

  // Both pins pass two flip-flops; the third stage only serves edge detection.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= serial_clock_pin;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= serial_data_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // Straps are resynchronised too, so a change is seen cleanly.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sel_m <= 1'b1;
      sel_s <= 1'b1;
      asel_m <= 1'b0;
      asel_s <= 1'b0;
    end else begin
      sel_m <= interface_select_pin;
      sel_s <= sel_m;
      asel_m <= address_select_pin;
      asel_s <= asel_m;
    end
  end

  assign two_wire = ~sel_s;
  assign own_addr = asel_s ? PTC_DEV_ADDR_STRAP_HIGH : PTC_DEV_ADDR_STRAP_LOW;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  // Data moving while the clock stays high is a start or a stop.
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  assign byte_done = (state == PTC_RECV) && scl_fall && (bit_cnt == PTC_BITS_PER_BYTE);
  assign ctrl_hit = (reg_req.addr == PTC_REG_SERIAL_PORT_CONTROL);
  // The read bit is refused while writes alone are allowed.
  assign dev_match = (shreg[7:1] == own_addr) && !(shreg[0] && write_only_mode);
  // A second word without address stepping is not acknowledged.
  assign accept = !(words_done && !address_step_enable);
  assign word_write = byte_done && (byte_idx == PTC_IDX_DATA) && data_lo && accept;

  // The first read word is fetched during the address acknowledge clock.
  assign fetch_first = (state == PTC_ACK) && scl_rise && rw && (byte_idx == PTC_IDX_DEVICE);
  // Later words are fetched when the master acknowledges a low byte.
  assign fetch_next = (state == PTC_MACK) && scl_rise && !sda_s && data_lo && address_step_enable;
  assign fetch_req = fetch_first | fetch_next;

  // Bytes past a word that may not step are sent as a released line.
  always_comb begin
    tx_byte = data_lo ? tx_word[7:0] : tx_word[15:8];
    if (words_done && !address_step_enable) begin
      tx_byte = PTC_BYTE_RELEASED;
    end
    next_byte = tx_word[7:0];
    if (data_lo) begin
      next_byte = address_step_enable ? tx_word[15:8] : PTC_BYTE_RELEASED;
    end else if (words_done && !address_step_enable) begin
      next_byte = PTC_BYTE_RELEASED;
    end
  end

  // Bit-level protocol engine.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= PTC_IDLE;
      bit_cnt <= PTC_BIT_FIRST;
      shreg <= PTC_BYTE_RESET;
      hi_byte <= PTC_BYTE_RESET;
      byte_idx <= PTC_IDX_DEVICE;
      data_lo <= 1'b0;
      rw <= 1'b0;
      words_done <= 1'b0;
      serial_data_oe <= 1'b0;
    end else if (!two_wire || stop_cond) begin
      state <= PTC_IDLE;
      serial_data_oe <= 1'b0;
    end else if (start_cond) begin
      // A start anywhere restarts address reception, which also serves a repeated start.
      state <= PTC_RECV;
      bit_cnt <= PTC_BIT_FIRST;
      byte_idx <= PTC_IDX_DEVICE;
      data_lo <= 1'b0;
      words_done <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      case (state)
        PTC_IDLE: begin
          serial_data_oe <= 1'b0;
        end
        PTC_RECV: begin
          if (scl_rise && (bit_cnt != PTC_BITS_PER_BYTE)) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + PTC_BIT_STEP;
          end else if (byte_done) begin
            if (byte_idx == PTC_IDX_DEVICE) begin
              if (dev_match) begin
                rw <= shreg[0];
                state <= PTC_ACK;
                serial_data_oe <= 1'b1;
              end else begin
                state <= PTC_IDLE;
              end
            end else begin
              state <= PTC_ACK;
              serial_data_oe <= accept;
              if (byte_idx == PTC_IDX_DATA && accept) begin
                hi_byte <= shreg;
                data_lo <= ~data_lo;
                if (data_lo) begin
                  words_done <= 1'b1;
                end
              end
            end
            if (!rw || byte_idx == PTC_IDX_DEVICE) begin
              if (byte_idx != PTC_IDX_DATA && (byte_idx != PTC_IDX_DEVICE || !shreg[0])) begin
                byte_idx <= byte_idx + PTC_IDX_STEP;
              end
            end
          end
        end
        PTC_ACK: begin
          if (scl_fall) begin
            bit_cnt <= PTC_BIT_FIRST;
            if (rw) begin
              state <= PTC_SEND;
              serial_data_oe <= ~tx_byte[7];
            end else begin
              state <= PTC_RECV;
              serial_data_oe <= 1'b0;
            end
          end
        end
        PTC_SEND: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + PTC_BIT_STEP;
          end else if (scl_fall) begin
            if (bit_cnt == PTC_BITS_PER_BYTE) begin
              state <= PTC_MACK;
              serial_data_oe <= 1'b0;
            end else begin
              // Only a zero is driven; a one leaves the pull-up in charge.
              serial_data_oe <= ~tx_byte[~bit_cnt[2:0]];
            end
          end
        end
        PTC_MACK: begin
          if (scl_rise && sda_s) begin
            state <= PTC_IDLE;
          end else if (scl_fall) begin
            state <= PTC_SEND;
            bit_cnt <= PTC_BIT_FIRST;
            data_lo <= ~data_lo;
            if (data_lo) begin
              words_done <= 1'b1;
            end
            serial_data_oe <= ~next_byte[7];
          end
        end
        default: begin
          state <= PTC_IDLE;
          serial_data_oe <= 1'b0;
        end
      endcase
    end
  end

  // The data pin is open drain: its output value is a constant low.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= 1'b0;
    end
  end

  // Register address: loaded high byte first, then stepped after each written word and before each further read word.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_req.addr <= PTC_ADDR_RESET;
    end else if (byte_done && accept && !rw && byte_idx == PTC_IDX_ADDR_HI) begin
      reg_req.addr[15:8] <= shreg;
    end else if (byte_done && accept && !rw && byte_idx == PTC_IDX_ADDR_LO) begin
      reg_req.addr[7:0] <= shreg;
    end else if ((reg_req.wr || word_write && ctrl_hit) && address_step_enable) begin
      reg_req.addr <= reg_req.addr + PTC_ADDR_STEP;
    end else if (fetch_next) begin
      reg_req.addr <= reg_req.addr + PTC_ADDR_STEP;
    end
  end

  // Write and read strobes to the register map, one cycle each.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_req.wr <= 1'b0;
      reg_req.rd <= 1'b0;
      reg_req.wdata <= PTC_WORD_RESET;
      rd_d1 <= 1'b0;
    end else begin
      reg_req.wr <= word_write && !ctrl_hit;
      reg_req.rd <= fetch_req;
      rd_d1 <= reg_req.rd;
      if (word_write) begin
        reg_req.wdata <= {hi_byte, shreg};
      end
    end
  end

  // Read word capture; the local control register answers for its own address.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_word <= PTC_WORD_RESET;
    end else if (rd_d1) begin
      tx_word <= ctrl_hit ? ctrl : reg_rdata;
    end
  end

  // Serial port control register; only the step bit is implemented.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl <= PTC_CTRL_RESET;
    end else if (word_write && ctrl_hit) begin
      ctrl <= {hi_byte, shreg} & PTC_CTRL_WMASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      address_step_enable <= PTC_CTRL_RESET[PTC_STEP_BIT];
    end else begin
      address_step_enable <= ctrl[PTC_STEP_BIT];
    end
  end

endmodule // ptc_two_wire_port

// ---- tb/ptc_two_wire_properties.sv ----
// Purpose: Assertions on the pins and map strobes of the control port.
// Assumes: One clock domain; serial pins far slower than the clock.
// Notes: Bound to every instance of the port.
module ptc_two_wire_properties
  import ptc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic interface_select_pin,
  input wire logic address_select_pin,
  input wire logic write_only_mode,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire ptc_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic address_step_enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Six cycles cover the select synchroniser and the output register.
  sequence port_off;
    interface_select_pin [*6];
  endsequence
  // By the fourth high sample any reaction to the last clock fall has landed.
  sequence clock_high;
    serial_clock_pin [*4];
  endsequence
  out_zero_a: assert property (serial_data_out == 1'b0)
    else $error("data pin driven high");
  wr_pulse_a: assert property (reg_req.wr |=> !reg_req.wr)
    else $error("write strobe too long");
  rd_pulse_a: assert property (reg_req.rd |=> !reg_req.rd && !reg_req.wr)
    else $error("read strobe too long");
  wr_ack_a: assert property (reg_req.wr |-> serial_data_oe)
    else $error("write without acknowledge");
  addr_step_a: assert property (reg_req.wr && address_step_enable |=>
    reg_req.addr == $past(reg_req.addr) + 16'h0001) else $error("address not stepped");
  addr_hold_a: assert property (reg_req.wr && !address_step_enable |=>
    $stable(reg_req.addr)) else $error("address stepped while disabled");
  port_idle_a: assert property (port_off |-> !serial_data_oe && !reg_req.wr && !reg_req.rd)
    else $error("port active while deselected");
  data_steady_a: assert property (clock_high |-> $stable(serial_data_oe))
    else $error("data changed while clock high");
endmodule // ptc_two_wire_properties

bind ptc_two_wire_port ptc_two_wire_properties ptc_two_wire_properties_i (.*);

// ---- tb/ptc_host_model.sv ----
// Purpose: Behavioural two-wire bus master for the control port.
// Assumes: Pull-ups on both wires; 400 ns serial clock period.
// Notes: The clock stands high between frames.
module ptc_host_model
  import ptc_pkg::*;
(
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic q();
    repeat (2) @(posedge clock);
  endtask
  task automatic start();
    sda_oe <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b0;
    q();
  endtask
  // Nine bits, high first; the last is the acknowledge slot.
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_oe <= !tx[i];
      q();
      scl <= 1'b1;
      q();
      rx[i] = sda;
      q();
      scl <= 1'b0;
      q();
    end
  endtask
endmodule // ptc_host_model

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the two-wire control port.
// Assumes: The host model drives the wires; an array stands in for the map.
// Notes: Map addresses fold to four bits.
module tb
  import ptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic interface_select_pin = 1'b0;
  logic address_select_pin = 1'b0;
  logic write_only_mode = 1'b0;
  logic serial_clock_pin;
  logic host_oe;
  logic serial_data_out;
  logic serial_data_oe;
  logic address_step_enable;
  ptc_reg_req_t reg_req;
  logic [15:0] reg_rdata = 16'h0000;
  logic [15:0] mem [16] = '{default: 16'h0000};
  int bad_count = 0;
  int num_checks = 0;
  wire logic serial_data_in = !(host_oe || (serial_data_oe && !serial_data_out));
  initial begin
    forever #25 clock = ~clock;
  end
  ptc_two_wire_port ptc_two_wire_port_i (.*);
  ptc_host_model ptc_host_model_i (
    .clock(clock),
    .sda(serial_data_in),
    .scl(serial_clock_pin),
    .sda_oe(host_oe)
  );
  always @(posedge clock) begin
    if (reg_req.rd) reg_rdata <= mem[reg_req.addr[3:0]];
    if (reg_req.wr) mem[reg_req.addr[3:0]] <= reg_req.wdata;
  end
  task automatic stop_test();
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic st();
    ptc_host_model_i.start();
  endtask
  task automatic sp();
    ptc_host_model_i.stop();
  endtask
  task automatic sb(input logic [7:0] b, input logic ack);
    logic [8:0] r;
    ptc_host_model_i.byte_io({b, 1'b1}, r);
    chk({15'h0000, r[0]}, {15'h0000, !ack});
  endtask
  task automatic rb(input logic [7:0] e, input logic last);
    logic [8:0] r;
    ptc_host_model_i.byte_io({8'hFF, last}, r);
    chk({8'h00, r[8:1]}, {8'h00, e});
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    chk({15'h0000, address_step_enable}, 16'h0001);
    st(); sb(8'h68, 1); sb(8'h00, 1); sb(8'h02, 1);
    sb(8'h12, 1); sb(8'h34, 1); sb(8'h56, 1); sb(8'h78, 1); sp();
    chk(mem[2], 16'h1234);
    chk(mem[3], 16'h5678);
    st(); sb(8'h68, 1); sb(8'h00, 1); sb(8'h02, 1); st(); sb(8'h69, 1);
    rb(8'h12, 0); rb(8'h34, 0); rb(8'h56, 0); rb(8'h78, 1); sp();
    st(); sb(8'h6C, 0); sb(8'h00, 0); sp();
    address_select_pin <= 1'b1;
    st(); sb(8'h6C, 1); sb(8'h00, 1); sb(8'h05, 1); sb(8'hBE, 1); sb(8'hEF, 1); sp();
    chk(mem[5], 16'hBEEF);
    address_select_pin <= 1'b0;
    write_only_mode <= 1'b1;
    st(); sb(8'h69, 0); sp();
    write_only_mode <= 1'b0;
    st(); sb(8'h68, 1); sb(8'h40, 1); sb(8'h07, 1); sb(8'h00, 1); sb(8'h00, 1); sp();
    chk({15'h0000, address_step_enable}, 16'h0000);
    st(); sb(8'h68, 1); sb(8'h00, 1); sb(8'h08, 1); sb(8'h11, 1); sb(8'h22, 1);
    sb(8'h33, 0); sb(8'h44, 0); sp();
    chk(mem[8], 16'h1122);
    chk(mem[9], 16'h0000);
    st(); sb(8'h68, 1); sb(8'h40, 1); sb(8'h07, 1); sb(8'h00, 1); sb(8'h04, 1); sp();
    st(); sb(8'h68, 1); sb(8'h40, 1); sb(8'h07, 1); st(); sb(8'h69, 1);
    rb(8'h00, 0); rb(8'h04, 1); sp();
    st(); sb(8'h69, 1); rb(8'h00, 0); rb(8'h04, 1); sp();
    st(); sb(8'h68, 1); sb(8'h00, 1); sb(8'h0A, 1); sb(8'hAB, 1); sp();
    chk(mem[10], 16'h0000);
    interface_select_pin <= 1'b1;
    st(); sb(8'h68, 0); sp();
    interface_select_pin <= 1'b0;
    stop_test();
  end
endmodule // tb
